// File: serial_rx_pkg.sv
// constants, field layouts and carrier types for the serial receive status block
package serial_rx_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h14;
  localparam logic [7:0] ADDR_CONTROL_THREE = 8'h15;
  localparam logic [7:0] ADDR_STATUS_ONE    = 8'h16;
  localparam logic [7:0] ADDR_STATUS_TWO    = 8'h17;
  localparam logic [7:0] ADDR_DATA_BUFFER   = 8'h18;
  localparam logic [7:0] ADDR_BIT_RATE      = 8'h19;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // control_two
  localparam int POS_RX_FULL_IRQ_EN    = 5;
  localparam int POS_LINE_QUIET_IRQ_EN = 4;
  localparam int POS_RX_ENABLE         = 2;
  // control_three
  localparam int POS_RX_NINTH_BIT      = 7;
  localparam int POS_OVERRUN_IRQ_EN    = 3;
  localparam int POS_NOISE_IRQ_EN      = 2;
  localparam int POS_FRAMING_IRQ_EN    = 1;
  localparam int POS_PARITY_IRQ_EN     = 0;
  // status_one: clearable flag vector index equals bit position
  localparam int FLAG_COUNT            = 6;
  localparam int POS_RX_FULL           = 5;
  localparam int POS_LINE_QUIET        = 4;
  localparam int POS_OVERRUN           = 3;
  localparam int POS_NOISE             = 2;
  localparam int POS_FRAMING           = 1;
  localparam int POS_PARITY            = 0;
  // status_two
  localparam int POS_BREAK_SEEN        = 1;
  localparam int POS_RECEPTION_ACTIVE  = 0;
  // bit_rate_select
  localparam int POS_PRESCALE_LSB      = 4;
  localparam int POS_DIVISOR_LSB       = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL    = 8'h00;
  localparam logic [7:0] RESET_BIT_RATE   = 8'h00;
  localparam logic [5:0] RESET_FLAGS      = 6'h00;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0]  IDLE_BITS_EIGHT  = 4'hA;
  localparam logic [3:0]  IDLE_BITS_NINE   = 4'hB;
  localparam logic [13:0] CLOCKS_PER_BIT   = 14'h0040;
  localparam logic [12:0] CLOCKS_PER_SAMPLE = 13'h0004;
  localparam logic [3:0]  PRESCALE_DIV_0   = 4'h1;
  localparam logic [3:0]  PRESCALE_DIV_1   = 4'h3;
  localparam logic [3:0]  PRESCALE_DIV_2   = 4'h4;
  localparam logic [3:0]  PRESCALE_DIV_3   = 4'hD;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       char_done;
    logic [7:0] data;
    logic       ninth;
    logic       noise;
    logic       framing;
    logic       parity;
    logic       brk;
    logic       start_low;
    logic       false_start;
  } rx_event_t;

  typedef enum logic [1:0] {
    CLR_NONE  = 2'b01,
    CLR_ARMED = 2'b10
  } clear_state_t;

endpackage

// File: serial_rx_status_and_baud.sv
// receive status flags, data buffer and bit-rate divider of an asynchronous serial port
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module serial_rx_status_and_baud
  import serial_rx_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire rx_event_t  i_rx_event,
  input  wire logic       i_nine_bit_mode,
  input  wire logic       i_rx_pin,
  output logic      [7:0] o_rdata,
  output logic            o_rx_irq,
  output logic            o_err_irq,
  output logic      [7:0] o_tx_byte,
  output logic            o_tx_load,
  output logic            o_sample_tick,
  output logic            o_bit_tick,
  output logic            o_rx_enable
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]           control_two;
  logic [7:0]           control_three;
  logic [7:0]           bit_rate_select;
  logic [7:0]           rx_data;
  logic                 rx_ninth_bit;
  logic [FLAG_COUNT-1:0] flags;
  logic [FLAG_COUNT-1:0] snap;
  logic                 break_seen_flag;
  logic                 break_snap;
  logic                 break_rearm;
  logic                 reception_active_flag;
  clear_state_t         clear_state;

  logic                 rx_s1;
  logic                 rx_s2;
  logic                 rx_s3;
  logic                 rx_high;
  logic [3:0]           idle_cnt;
  logic                 idle_armed;
  logic [3:0]           pre_cnt;
  logic [12:0]          div_cnt;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic                  wr_ctl2;
  logic                  wr_ctl3;
  logic                  wr_rate;
  logic                  wr_data;
  logic                  rd_s1;
  logic                  rd_s2;
  logic                  rd_data;
  logic                  clearing;
  logic [FLAG_COUNT-1:0] clr_vec;
  logic [FLAG_COUNT-1:0] set_vec;
  logic                  brk_ok;
  logic                  new_char;
  logic                  accept;
  logic [3:0]            idle_thr;
  logic                  idle_char;
  logic                  idle_hit;
  logic [3:0]            pd;
  logic [13:0]           bit_limit_wide;
  logic [12:0]           bit_limit;
  logic [12:0]           sample_mask;
  logic                  pre_wrap;

  assign wr_ctl2  = i_wr && (i_addr == ADDR_CONTROL_TWO);
  assign wr_ctl3  = i_wr && (i_addr == ADDR_CONTROL_THREE);
  assign wr_rate  = i_wr && (i_addr == ADDR_BIT_RATE);
  assign wr_data  = i_wr && (i_addr == ADDR_DATA_BUFFER);
  assign rd_s1    = i_rd && (i_addr == ADDR_STATUS_ONE);
  assign rd_s2    = i_rd && (i_addr == ADDR_STATUS_TWO);
  assign rd_data  = i_rd && (i_addr == ADDR_DATA_BUFFER);
  assign clearing = rd_data && (clear_state == CLR_ARMED);
  assign clr_vec  = {FLAG_COUNT{clearing}} & snap;

  // a break only counts once the line has been high since the last one
  assign brk_ok   = i_rx_event.brk && break_rearm;
  assign new_char = i_rx_event.char_done || brk_ok;
  // a buffer being emptied in this very cycle can take the new character
  assign accept   = new_char && (!flags[POS_RX_FULL] || clr_vec[POS_RX_FULL]);

  assign idle_thr  = i_nine_bit_mode ? IDLE_BITS_NINE : IDLE_BITS_EIGHT;
  assign idle_char = o_bit_tick && rx_high && (idle_cnt == idle_thr - 4'h1);
  assign idle_hit  = idle_char && idle_armed && control_two[POS_RX_ENABLE];

  always_comb begin
    set_vec               = '0;
    set_vec[POS_RX_FULL]  = accept;
    set_vec[POS_LINE_QUIET] = idle_hit;
    set_vec[POS_OVERRUN]  = new_char && !accept;
    set_vec[POS_NOISE]    = i_rx_event.noise;
    set_vec[POS_FRAMING]  = i_rx_event.framing || brk_ok;
    set_vec[POS_PARITY]   = i_rx_event.parity;
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      control_two     <= RESET_CONTROL;
      control_three   <= RESET_CONTROL;
      bit_rate_select <= RESET_BIT_RATE;
    end else begin
      if (wr_ctl2) begin
        control_two <= i_wdata & 8'h34;
      end
      if (wr_ctl3) begin
        control_three <= i_wdata & 8'h0F;
      end
      if (wr_rate) begin
        bit_rate_select <= i_wdata & 8'h37;
      end
    end
  end

  // data buffer keeps its contents through reset
  always_ff @(posedge i_clk_sys) begin
    if (accept) begin
      rx_data <= brk_ok ? 8'h00 : i_rx_event.data;
      if (i_nine_bit_mode) begin
        rx_ninth_bit <= brk_ok ? 1'b0 : i_rx_event.ninth;
      end else begin
        rx_ninth_bit <= i_rx_event.data[7];
      end
    end
    if (wr_data) begin
      o_tx_byte <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_tx_load <= 1'b0;
    end else begin
      o_tx_load <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // clearable flags: set wins over a clear in the same cycle
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < FLAG_COUNT; g++) begin : g_flag
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          flags[g] <= RESET_FLAGS[g];
        end else begin
          flags[g] <= set_vec[g] || (flags[g] && !clr_vec[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      clear_state <= CLR_NONE;
      snap        <= '0;
      break_snap  <= 1'b0;
    end else begin
      case (clear_state)
        CLR_NONE: begin
          if (rd_s1 || rd_s2) begin
            clear_state <= CLR_ARMED;
          end
        end
        CLR_ARMED: begin
          if (rd_data) begin
            clear_state <= CLR_NONE;
          end
        end
        default: begin
          clear_state <= CLR_NONE;
        end
      endcase
      if (rd_s1) begin
        snap <= flags;
      end else if (rd_data) begin
        snap <= '0;
      end
      if (rd_s2) begin
        break_snap <= break_seen_flag;
      end else if (rd_data) begin
        break_snap <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      break_seen_flag <= 1'b0;
      break_rearm     <= 1'b1;
    end else begin
      break_seen_flag <= brk_ok || (break_seen_flag && !(clearing && break_snap));
      if (brk_ok) begin
        break_rearm <= 1'b0;
      end else if (rx_high) begin
        break_rearm <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      reception_active_flag <= 1'b0;
    end else if (i_rx_event.start_low) begin
      reception_active_flag <= 1'b1;
    end else if (i_rx_event.false_start || idle_char) begin
      reception_active_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive line watch and idle detection
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_high <= 1'b1;
    end else begin
      rx_s1 <= i_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_high <= rx_s3;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      idle_cnt <= 4'h0;
    end else if (!rx_high) begin
      idle_cnt <= 4'h0;
    end else if (o_bit_tick && (idle_cnt != idle_thr)) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // arming drops when the receiver is off or once idle has fired
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      idle_armed <= 1'b0;
    end else if (!control_two[POS_RX_ENABLE] || idle_hit) begin
      idle_armed <= 1'b0;
    end else if (accept) begin
      idle_armed <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bit-rate divider
  // ---------------------------------------------------------------
  always_comb begin
    case (bit_rate_select[POS_PRESCALE_LSB +: 2])
      2'b00:   pd = PRESCALE_DIV_0;
      2'b01:   pd = PRESCALE_DIV_1;
      2'b10:   pd = PRESCALE_DIV_2;
      2'b11:   pd = PRESCALE_DIV_3;
      default: pd = PRESCALE_DIV_0;
    endcase
  end

  // widened by a bit so the largest divisor does not wrap
  assign bit_limit_wide = (CLOCKS_PER_BIT << bit_rate_select[POS_DIVISOR_LSB +: 3])
                          - 14'h0001;
  assign bit_limit   = bit_limit_wide[12:0];
  assign sample_mask = (CLOCKS_PER_SAMPLE << bit_rate_select[POS_DIVISOR_LSB +: 3])
                       - 13'h0001;
  assign pre_wrap    = (pre_cnt == pd - 4'h1);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pre_cnt <= 4'h0;
      div_cnt <= 13'h0000;
    end else begin
      if (pre_wrap || (pre_cnt >= pd)) begin
        pre_cnt <= 4'h0;
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
      if (pre_wrap) begin
        if (div_cnt >= bit_limit) begin
          div_cnt <= 13'h0000;
        end else begin
          div_cnt <= div_cnt + 13'h0001;
        end
      end
    end
  end

  // one tick pair feeds both receiver and transmitter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_bit_tick    <= 1'b0;
      o_sample_tick <= 1'b0;
    end else begin
      o_bit_tick    <= pre_wrap && (div_cnt == bit_limit);
      o_sample_tick <= pre_wrap && ((div_cnt & sample_mask) == sample_mask);
    end
  end

  // ---------------------------------------------------------------
  // interrupts and read data
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rx_irq    <= 1'b0;
      o_err_irq   <= 1'b0;
      o_rx_enable <= 1'b0;
    end else begin
      o_rx_irq  <= (flags[POS_RX_FULL] && control_two[POS_RX_FULL_IRQ_EN])
                || (flags[POS_LINE_QUIET] && control_two[POS_LINE_QUIET_IRQ_EN]);
      o_err_irq <= (flags[POS_OVERRUN] && control_three[POS_OVERRUN_IRQ_EN])
                || (flags[POS_NOISE] && control_three[POS_NOISE_IRQ_EN])
                || (flags[POS_FRAMING] && control_three[POS_FRAMING_IRQ_EN])
                || (flags[POS_PARITY] && control_three[POS_PARITY_IRQ_EN]);
      o_rx_enable <= control_two[POS_RX_ENABLE];
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CONTROL_TWO:   o_rdata <= control_two;
        ADDR_CONTROL_THREE: o_rdata <= {rx_ninth_bit, control_three[6:0]};
        ADDR_STATUS_ONE:    o_rdata <= {2'b00, flags};
        ADDR_STATUS_TWO:    o_rdata <= {6'h00, break_seen_flag, reception_active_flag};
        ADDR_DATA_BUFFER:   o_rdata <= rx_data;
        ADDR_BIT_RATE:      o_rdata <= bit_rate_select;
        default:            o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_full_on_char: assert property (
    (i_rx_event.char_done && !i_rx_event.brk && !flags[POS_RX_FULL])
      |=> flags[POS_RX_FULL] && (rx_data == $past(i_rx_event.data)))
    else $error("full flag or buffer not loaded by character");

  a_rx_irq_level: assert property (
    (flags[POS_RX_FULL] && control_two[POS_RX_FULL_IRQ_EN]) |=> o_rx_irq)
    else $error("receive interrupt missing");

  a_full_clear_seq: assert property (
    (rd_s1 && flags[POS_RX_FULL]) ##1 (rd_data && !i_rx_event.char_done && !i_rx_event.brk)
      |=> !flags[POS_RX_FULL])
    else $error("full flag survived clearing sequence");

  a_idle_count: assert property (
    $rose(flags[POS_LINE_QUIET]) |-> ($past(idle_cnt) == idle_thr - 4'h1) && $past(rx_high))
    else $error("idle flag set before enough high bits");

  a_idle_armed: assert property (
    $rose(flags[POS_LINE_QUIET]) |-> $past(idle_armed))
    else $error("idle flag set while not armed");

  a_overrun_keep: assert property (
    (i_rx_event.char_done && flags[POS_RX_FULL] && !rd_data)
      |=> flags[POS_OVERRUN] && $stable(rx_data))
    else $error("overrun not flagged or buffer overwritten");

  a_overrun_late: assert property (
    (rd_s1 && !flags[POS_OVERRUN]) ##1 (rd_data && flags[POS_OVERRUN]) |=> flags[POS_OVERRUN])
    else $error("overrun cleared without status read");

  a_err_irq: assert property (
    (flags[POS_OVERRUN] && control_three[POS_OVERRUN_IRQ_EN]) |=> o_err_irq)
    else $error("error interrupt missing");

  a_break_sets: assert property (
    brk_ok |=> break_seen_flag && flags[POS_FRAMING] && flags[POS_RX_FULL])
    else $error("break did not set its flags");

  a_rpf_clear: assert property (
    (i_rx_event.false_start && !i_rx_event.start_low) |=> !reception_active_flag)
    else $error("reception flag not cleared by false start");

  a_prescale_range: assert property (
    pre_wrap |=> (pre_cnt == 4'h0) ##[1:12] pre_wrap)
    else $error("prescaler period wrong");

  c_char_read: cover property (rd_s1 ##1 rd_data ##1 !flags[POS_RX_FULL]);
  c_overrun: cover property (set_vec[POS_OVERRUN]);
  c_idle: cover property (idle_hit);
  c_break: cover property (brk_ok);

endmodule

// File: serial_peer.sv
// remote transmitter model: receive line level and receiver event pulses
`timescale 1ns/1ns
module serial_peer
  import serial_rx_pkg::*;
(
  input  wire logic i_clk_sys,
  output rx_event_t o_event,
  output logic      o_line
);
  initial begin
    o_event = '0;
    o_line  = 1'b1;
  end
  // each event is a one-clock pulse, as the receiver core reports it
  task automatic send(input rx_event_t e);
    @(posedge i_clk_sys);
    o_event <= e;
    @(posedge i_clk_sys);
    o_event <= '0;
  endtask
  // line held low while a stream of frames runs, high when quiet
  task automatic line(input logic v);
    @(posedge i_clk_sys);
    o_line <= v;
  endtask
endmodule

// File: tb_top.sv
// self-checking bench for the serial receive status and bit-rate block
`timescale 1ns/1ns
module tb_top
  import serial_rx_pkg::*;
;
  localparam logic [7:0] S1 = ADDR_STATUS_ONE;
  localparam logic [7:0] S2 = ADDR_STATUS_TWO;
  localparam logic [7:0] DB = ADDR_DATA_BUFFER;
  localparam logic [7:0] C3 = ADDR_CONTROL_THREE;
  logic       clk, rst_n, wr, rd, nine, rx_irq, err_irq, tx_load, stk, btk, rx_en, pin;
  logic [7:0] addr, wdata, rdata, tx_byte;
  rx_event_t  ev;
  int         fail_count, num_checks, n, i;
  int         pd[4] = '{1, 3, 4, 13};

  serial_peer peer (.i_clk_sys(clk), .o_event(ev), .o_line(pin));
  serial_rx_status_and_baud dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_rx_event(ev), .i_nine_bit_mode(nine),
    .i_rx_pin(pin), .o_rdata(rdata), .o_rx_irq(rx_irq), .o_err_irq(err_irq),
    .o_tx_byte(tx_byte), .o_tx_load(tx_load), .o_sample_tick(stk),
    .o_bit_tick(btk), .o_rx_enable(rx_en));

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // status read straight followed by a data read, as a clearing routine does it
  task automatic rseq(input string nm, input logic [7:0] a, se, de);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    addr <= DB;
    #1 chk(nm, rdata, se);
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, de);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask
  function automatic rx_event_t ch(input logic [7:0] d, input logic [3:0] f);
    return '{char_done:1'b1, data:d, ninth:f[3], noise:f[2], framing:f[1],
             parity:f[0], default:'0};
  endfunction
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // count clocks from one bit or sample tick to the next; the first tick after a
  // rate change may come early, so it only starts the count
  task automatic gap(input logic smp, output int k);
    for (int j = 0; j < 2; j++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while ((smp ? stk : btk) !== 1'b1 && k < 20000);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1400000;
    fail_count++;
    final_report;
  end
  initial begin
    {rst_n, wr, rd, nine, addr, wdata} = '0;
    do_reset;
    rchk("status one", S1, 8'h00);
    rchk("bit rate", ADDR_BIT_RATE, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    peer.line(1'b0);
    peer.send(ch(8'hC3, 4'h0));
    do_reset;
    rchk("status after reset", S1, 8'h00);
    rchk("buffer kept", DB, 8'hC3);
    bus_wr(ADDR_CONTROL_TWO, 8'h34);
    bus_wr(C3, 8'h0F);
    bus_wr(DB, 8'h5A);
    #1 chk("tx load", {tx_load, tx_byte}, 9'h15A);
    chk("rx enable", rx_en, 1'b1);
    rchk("rx side", DB, 8'hC3);
    peer.send(ch(8'hA5, 4'h0));
    repeat (2) @(negedge clk);
    chk("rx irq", rx_irq, 1'b1);
    rseq("full then data", S1, 8'h20, 8'hA5);
    rchk("cleared", S1, 8'h00);
    peer.send(ch(8'h11, 4'h0));
    peer.send(ch(8'h22, 4'h0));
    rchk("overrun", S1, 8'h28);
    chk("err irq", err_irq, 1'b1);
    rchk("kept byte", DB, 8'h11);
    rchk("cleared", S1, 8'h00);
    peer.send(ch(8'h33, 4'h0));
    // the next character lands on the very edge of the status read
    fork
      peer.send(ch(8'h44, 4'h0));
      rseq("late data", S1, 8'h20, 8'h33);
    join
    rchk("second read", S1, 8'h08);
    rchk("lost byte", DB, 8'h33);
    rchk("cleared", S1, 8'h00);
    peer.send(ch(8'h55, 4'h7));
    rchk("errors", S1, 8'h27);
    chk("err irq", err_irq, 1'b1);
    rchk("data", DB, 8'h55);
    rchk("cleared", S1, 8'h00);
    chk("err irq low", err_irq, 1'b0);
    nine <= 1'b1;
    peer.send(ch(8'h66, 4'h8));
    rchk("ninth bit", C3, 8'h8F);
    rchk("full", S1, 8'h20);
    rchk("data", DB, 8'h66);
    peer.line(1'b1);
    repeat (6) @(posedge clk);
    peer.line(1'b0);
    // a break only follows a line that has been held low for a while
    repeat (6) @(posedge clk);
    peer.send('{brk:1'b1, default:'0});
    rchk("break s1", S1, 8'h22);
    rchk("break s2", S2, 8'h02);
    rchk("break ninth", C3, 8'h0F);
    rchk("break data", DB, 8'h00);
    rchk("break gone", S2, 8'h00);
    peer.send('{brk:1'b1, default:'0});
    rchk("no rearm", S2, 8'h00);
    peer.send('{start_low:1'b1, default:'0});
    rchk("active", S2, 8'h01);
    peer.send('{false_start:1'b1, default:'0});
    rchk("false start", S2, 8'h00);
    nine <= 1'b0;
    peer.send(ch(8'h77, 4'h0));
    rchk("full", S1, 8'h20);
    rchk("data", DB, 8'h77);
    peer.send('{start_low:1'b1, default:'0});
    peer.line(1'b1);
    n = 0;
    while (rx_irq !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("idle time", n >= 576 && n <= 650, 1'b1);
    rchk("idle", S1, 8'h10);
    rchk("idle ends rx", S2, 8'h00);
    rchk("data", DB, 8'h77);
    repeat (800) @(posedge clk);
    rchk("not armed", S1, 8'h00);
    for (i = 0; i < 11; i++) begin
      bus_wr(ADDR_BIT_RATE, (i < 4) ? 8'(i << 4) : 8'(i - 3));
      gap(1'b0, n);
      chk("bit period", 16'(n), 16'((i < 4) ? 64 * pd[i] : 64 << (i - 3)));
    end
    gap(1'b1, n);
    chk("sample period", 16'(n), 16'(4 << 7));
    rchk("rate read", ADDR_BIT_RATE, 8'h07);
    final_report;
  end
endmodule
